// ===== hdl/lcdfi_pkg.sv
// package: register map, field positions and reset values of the lcd frame block
`default_nettype none
package lcdfi_pkg;
  // geometry of the upper segment bank
  localparam int NUM_PIX = 12;
  localparam int NUM_COM = 4;
  localparam int NUM_SEG = 18;
  localparam int PIX_PER_COM = 3;
  // byte offsets on the register bus
  localparam logic [7:0] OFF_PIX_BASE = 8'h00;
  localparam logic [7:0] OFF_CTRL     = 8'h30;
  localparam logic [7:0] OFF_STATUS   = 8'h34;
  localparam logic [7:0] OFF_MASK     = 8'h38;
  localparam logic [7:0] OFF_STATE    = 8'h3C;
  // word indices of the control group
  localparam logic [3:0] IDX_CTRL   = 4'hC;
  localparam logic [3:0] IDX_STATUS = 4'hD;
  localparam logic [3:0] IDX_MASK   = 4'hE;
  localparam logic [3:0] IDX_STATE  = 4'hF;
  // lcd_control_register fields
  localparam int CTRL_EN      = 7;
  localparam int CTRL_SLPSEL  = 6;
  localparam int CTRL_WRITE_ERROR_FLAG    = 5;
  localparam int CTRL_TYPEB   = 4;
  localparam int CTRL_DIVCLK  = 3;
  localparam int CTRL_MUX_LO  = 0;
  localparam logic [7:0] CTRL_RST = 8'h03;
  // multiplex_select encodings
  localparam logic [1:0] MUX_STATIC = 2'h0;
  localparam logic [1:0] MUX_QUART  = 2'h3;
  // status and mask fields
  localparam int ST_FRAME = 0;
  localparam int ST_WRITE_ERROR_FLAG  = 1;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST   = 2'h0;
  localparam logic [7:0] PIX_RST    = 8'h00;

  // whole state of the block, registered in one place
  typedef struct packed {
    logic [7:0]                  ctrl;
    logic [NUM_PIX-1:0][7:0]     pix;
    logic [1:0]                  status;
    logic [1:0]                  mask;
    logic [1:0]                  slot;
    logic                        half;
    logic                        odd;
    logic                        window;
    logic [NUM_COM-1:0]          com_out;
    logic [NUM_COM-1:0]          com_drive;
    logic [NUM_SEG-1:0]          seg_out;
    logic                        irq;
    logic                        wake;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
  } lcdfi_state_s;
endpackage
`default_nettype wire

// ===== hdl/lcdfi_core.sv
// lcd waveform generator with frame interrupt and apb register file
//
// Function
// R1: waveforms keep zero DC on every pixel
// R2: one common per slot, segments carry its data
// R3: pixel sees only dark or clear rms
// R4: type A inverts phase inside each slot
// R5: type B inverts phase at frame boundary
// R6: divided system clock always stops in sleep
// R7: software sleeps only at zero pixel DC
// R8: frame starts at first common leading edge
// R9: frame interrupt after last pixel fetch
// R10: software writes pixels inside write window
// R11: type B pixel data stable per frame pair
// R12: type B interrupt only after frame pair
// R13: locked pixel write discarded, error flag set
// R14: no interrupt for type A or static
// R15: commons 0,1 use pixel registers 12-17
// R16: commons 2,3 use pixel registers 18-23
// R17: sleep select stops or keeps display running
// R18: wake at frame boundary when interrupt enabled
// R19: scan one to four commons per mux
`default_nettype none
module lcdfi_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              lcd_tick,
  input  wire logic              sleep_req,
  output var  logic [3:0]        com_out,
  output var  logic [3:0]        com_drive,
  output var  logic [17:0]       seg_out,
  output var  logic              irq,
  output var  logic              wake
);

  lcdfi_pkg::lcdfi_state_s s;
  lcdfi_pkg::lcdfi_state_s next_s;

  logic        acc_first;
  logic        acc_done;
  logic        hit;
  logic [3:0]  idx;
  logic [1:0]  mux;
  logic        type_b;
  logic        stopped;
  logic        gen_int;
  logic        wr_ok;
  logic        phase;
  logic        frame_evt;
  logic        write_error_flag_evt;
  logic [1:0]  rd_clear;
  logic [31:0] rd_word;
  logic [17:0] row;

  // a word is mapped when aligned and inside the sixteen-word window
  function automatic logic lcdfi_hit(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:6] == '0) && (a[1:0] == 2'h0);
  endfunction

  // pixel bits for one common, ascending segment order from bit 0
  function automatic logic [17:0] lcdfi_row(input logic [lcdfi_pkg::NUM_PIX-1:0][7:0] p,
                                            input logic [1:0] c);
    logic [17:0] r;
    r = 18'h0_0000;
    case (c)
      // R15: first two commons
      2'h0: r = {p[2][1:0], p[1], p[0]};
      2'h1: r = {p[5][1:0], p[4], p[3]};
      // R16: third and fourth commons
      2'h2: r = {p[8][1:0], p[7], p[6]};
      2'h3: r = {p[11][1:0], p[10], p[9]};
      default: r = 18'h0_0000;
    endcase
    return r;
  endfunction

  // decoded control fields
  assign mux    = s.ctrl[lcdfi_pkg::CTRL_MUX_LO +: 2];
  assign type_b = s.ctrl[lcdfi_pkg::CTRL_TYPEB];
  assign idx    = paddr[5:2];
  assign hit    = lcdfi_hit(paddr);

  // apb phases: one wait cycle so read data comes from a flop
  assign acc_first = psel && penable && !s.pready;
  assign acc_done  = psel && penable && s.pready;

  // R6: divided system clock ignores the sleep select
  // R17: otherwise the select decides stop or run
  assign stopped = sleep_req && (s.ctrl[lcdfi_pkg::CTRL_SLPSEL] ||
                                 s.ctrl[lcdfi_pkg::CTRL_DIVCLK]);

  // R14: only type B with more than one common interrupts
  assign gen_int = type_b && (mux != lcdfi_pkg::MUX_STATIC);

  // R11: pixel writes are locked outside the window in type B multiplex
  assign wr_ok = !s.ctrl[lcdfi_pkg::CTRL_EN] || !gen_int || s.window;

  // read mux; state word shows the live scan position
  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx < 4'(lcdfi_pkg::NUM_PIX)) begin
      rd_word[7:0] = s.pix[idx];
    end else if (idx == lcdfi_pkg::IDX_CTRL) begin
      rd_word[7:0] = s.ctrl;
    end else if (idx == lcdfi_pkg::IDX_STATUS) begin
      rd_word[1:0] = s.status;
    end else if (idx == lcdfi_pkg::IDX_MASK) begin
      rd_word[1:0] = s.mask;
    end else begin
      rd_word[4:0] = {s.odd, s.half, s.slot, s.ctrl[lcdfi_pkg::CTRL_EN] && !stopped};
    end
  end

  // next-state logic for bus, scan engine and outputs
  always_comb begin
    next_s    = s;
    frame_evt = 1'b0;
    write_error_flag_evt  = 1'b0;
    rd_clear  = 2'h0;
    row       = 18'h0_0000;
    phase     = 1'b0;
    if (ce) begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      next_s.wake    = 1'b0;
      // first access cycle latches read data and the error answer
      if (acc_first) begin
        next_s.pready  = 1'b1;
        next_s.pslverr = !hit;
        next_s.prdata  = hit ? rd_word : 32'h0000_0000;
      end
      // completion edge: writes land, status read clears what was shown
      if (acc_done && hit) begin
        if (pwrite) begin
          if (idx < 4'(lcdfi_pkg::NUM_PIX)) begin
            // R13: locked write is dropped and flagged
            if (wr_ok) begin
              next_s.pix[idx] = pwdata[7:0];
            end else begin
              write_error_flag_evt = 1'b1;
            end
          end else if (idx == lcdfi_pkg::IDX_CTRL) begin
            next_s.ctrl = pwdata[7:0];
            // error flag only clears by writing zero, never sets by software
            next_s.ctrl[lcdfi_pkg::CTRL_WRITE_ERROR_FLAG] = pwdata[lcdfi_pkg::CTRL_WRITE_ERROR_FLAG] &&
                                                s.ctrl[lcdfi_pkg::CTRL_WRITE_ERROR_FLAG];
          end else if (idx == lcdfi_pkg::IDX_MASK) begin
            next_s.mask = pwdata[1:0];
          end
        end else if (idx == lcdfi_pkg::IDX_STATUS) begin
          rd_clear = s.prdata[1:0];
        end
      end

      // scan engine
      if (!s.ctrl[lcdfi_pkg::CTRL_EN]) begin
        next_s.slot   = 2'h0;
        next_s.half   = 1'b0;
        next_s.odd    = 1'b0;
        next_s.window = 1'b0;
      end else if (!stopped && lcd_tick) begin
        if (!type_b && !s.half) begin
          // R4: type A second half of the slot is the inverse
          next_s.half = 1'b1;
        end else begin
          next_s.half = 1'b0;
          // R19: last slot index equals the mux setting
          if (s.slot == mux) begin
            next_s.slot = 2'h0;
            // R5: frame phase flips at each frame boundary
            next_s.odd  = !s.odd;
          end else begin
            next_s.slot = s.slot + 2'h1;
          end
          // R9: last row fetched in the second frame of the pair
          // R12: so the interrupt marks a complete phase interval
          if (gen_int && next_s.slot == mux && next_s.odd) begin
            frame_evt     = 1'b1;
            next_s.window = 1'b1;
          end
          // R8: boundary is the start of the first common slot
          if (next_s.slot == 2'h0 && !next_s.odd) begin
            next_s.window = 1'b0;
            // R18: wake on the pair boundary when frame interrupt enabled
            next_s.wake = sleep_req && gen_int && s.mask[lcdfi_pkg::ST_FRAME];
          end
        end
      end

      // sticky events: set wins over the read clear
      next_s.status = (s.status & ~rd_clear) | {write_error_flag_evt, frame_evt};
      if (write_error_flag_evt) begin
        next_s.ctrl[lcdfi_pkg::CTRL_WRITE_ERROR_FLAG] = 1'b1;
      end

      // drive waveforms from the next scan position
      row   = lcdfi_row(next_s.pix, next_s.slot);
      phase = next_s.ctrl[lcdfi_pkg::CTRL_TYPEB] ? next_s.odd : next_s.half;
      if (next_s.ctrl[lcdfi_pkg::CTRL_EN] && !stopped) begin
        // R2: only the active common is driven, the rest sit at mid bias
        next_s.com_drive = 4'h1 << next_s.slot;
        next_s.com_out   = phase ? (4'h1 << next_s.slot) : 4'h0;
        // R1: segment inverts with common so both halves cancel in DC
        // R3: pixel on gives opposite levels, pixel off gives equal levels
        next_s.seg_out   = row ^ {18{phase}};
      end else begin
        // R6: stopped panel is held at the minimum level
        next_s.com_drive = 4'h0;
        next_s.com_out   = 4'h0;
        next_s.seg_out   = 18'h0_0000;
      end
      next_s.irq = |(next_s.status & next_s.mask);
    end
  end

  // single state register; pixel data resets to PIX_RST along with the rest of the state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s           <= '0;
      s.ctrl      <= lcdfi_pkg::CTRL_RST;
      s.status    <= lcdfi_pkg::STATUS_RST;
      s.mask      <= lcdfi_pkg::MASK_RST;
      s.pix       <= {lcdfi_pkg::NUM_PIX{lcdfi_pkg::PIX_RST}};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign com_out   = s.com_out;
  assign com_drive = s.com_drive;
  assign seg_out   = s.seg_out;
  assign irq       = s.irq;
  assign wake      = s.wake;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // stopped module shows no drive on the next edge
  property p_stop_quiet;
    ce && stopped |=> (com_drive == 4'h0) && (seg_out == 18'h0_0000);
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("drive while stopped"); // R6 R17

  property p_one_com;
    $onehot0(com_drive);
  endproperty
  a_one_com: assert property (p_one_com) else $error("more than one common driven"); // R2

  property p_com_range;
    !(com_drive > (4'h1 << mux));
  endproperty
  a_com_range: assert property (p_com_range) else $error("common beyond mux"); // R19

  property p_pixel_code;
    (com_drive != 4'h0) |-> ((seg_out ^ {18{|com_out}}) == lcdfi_row(s.pix, s.slot));
  endproperty
  a_pixel_code: assert property (p_pixel_code) else $error("segment code mismatch"); // R1 R3 R15

  property p_typea_half;
    ce && s.ctrl[lcdfi_pkg::CTRL_EN] && !stopped && lcd_tick && !type_b && !s.half
      |=> s.half && (com_out == com_drive);
  endproperty
  a_typea_half: assert property (p_typea_half) else $error("type A did not invert"); // R4

  property p_typeb_flip;
    ce && s.ctrl[lcdfi_pkg::CTRL_EN] && !stopped && lcd_tick && type_b && (s.slot == mux)
      |=> (s.odd != $past(s.odd)) && (s.slot == 2'h0);
  endproperty
  a_typeb_flip: assert property (p_typeb_flip) else $error("type B phase not flipped"); // R5 R8

  property p_no_int;
    ce && !gen_int && !s.status[lcdfi_pkg::ST_FRAME] |=> !s.status[lcdfi_pkg::ST_FRAME];
  endproperty
  a_no_int: assert property (p_no_int) else $error("frame flag without type B mux"); // R14

  property p_int_place;
    $rose(s.status[lcdfi_pkg::ST_FRAME]) |-> s.window && (s.slot == mux) && s.odd;
  endproperty
  a_int_place: assert property (p_int_place) else $error("frame flag at wrong slot"); // R9 R12

  property p_write_error_flag;
    ce && acc_done && hit && pwrite && (idx < 4'(lcdfi_pkg::NUM_PIX)) && !wr_ok
      |=> s.ctrl[lcdfi_pkg::CTRL_WRITE_ERROR_FLAG] && s.status[lcdfi_pkg::ST_WRITE_ERROR_FLAG] && $stable(s.pix);
  endproperty
  a_write_error_flag: assert property (p_write_error_flag) else $error("locked write not rejected"); // R13

  property p_wake;
    wake |-> (s.slot == 2'h0) && !s.odd && s.half == 1'b0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake off boundary"); // R18

  // R18: wake is a single-cycle pulse
  property p_wake_pulse;
    ce && wake |=> !wake;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake held too long"); // R18

  // R9: interrupt line tracks unmasked sticky flags
  property p_irq_level;
    irq == |(s.status & s.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not matching flags"); // R9

  // R6: an undriven panel sits at the minimum level on every line
  property p_idle_level;
    (com_drive == 4'h0) |-> (com_out == 4'h0) && (seg_out == 18'h0_0000);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle lines not at minimum"); // R6

  // R19: disabled scan always restarts from the first common
  property p_disabled_reset;
    ce && !s.ctrl[lcdfi_pkg::CTRL_EN] |=> (s.slot == 2'h0) && !s.odd && !s.half;
  endproperty
  a_disabled_reset: assert property (p_disabled_reset) else $error("scan not parked"); // R19

  // R13: error flag stays until software writes the control word
  property p_write_error_flag_sticky;
    ce && s.ctrl[lcdfi_pkg::CTRL_WRITE_ERROR_FLAG] &&
      !(acc_done && hit && pwrite && (idx == lcdfi_pkg::IDX_CTRL))
      |=> s.ctrl[lcdfi_pkg::CTRL_WRITE_ERROR_FLAG];
  endproperty
  a_write_error_flag_sticky: assert property (p_write_error_flag_sticky) else $error("error flag lost"); // R13

  // R8: the write window shuts at the pair boundary
  property p_window_close;
    ce && s.window && s.ctrl[lcdfi_pkg::CTRL_EN] && !stopped && lcd_tick && type_b &&
      (s.slot == mux) |=> !s.window;
  endproperty
  a_window_close: assert property (p_window_close) else $error("window open past boundary"); // R8

  // R11: outside the window a pixel write leaves the data alone
  property p_locked_pix;
    ce && acc_done && hit && pwrite && (idx < 4'(lcdfi_pkg::NUM_PIX)) &&
      s.ctrl[lcdfi_pkg::CTRL_EN] && gen_int && !s.window |=> $stable(s.pix);
  endproperty
  a_locked_pix: assert property (p_locked_pix) else $error("locked pixel changed"); // R11 R13

  // R10: a write inside the window raises no error
  property p_open_write;
    ce && acc_done && hit && pwrite && (idx < 4'(lcdfi_pkg::NUM_PIX)) && s.window
      |=> s.status[lcdfi_pkg::ST_WRITE_ERROR_FLAG] == $past(s.status[lcdfi_pkg::ST_WRITE_ERROR_FLAG]);
  endproperty
  a_open_write: assert property (p_open_write) else $error("window write flagged"); // R10

  // R4: second type A tick returns to the plain phase
  property p_typea_second;
    ce && !acc_done && s.ctrl[lcdfi_pkg::CTRL_EN] && !stopped && lcd_tick && !type_b && s.half
      |=> !s.half && (com_out == 4'h0);
  endproperty
  a_typea_second: assert property (p_typea_second) else $error("type A half not restored"); // R4

  // R5: type B phase equals the frame parity
  property p_typeb_phase;
    (com_drive != 4'h0) && s.ctrl[lcdfi_pkg::CTRL_TYPEB] |-> ((|com_out) == s.odd);
  endproperty
  a_typeb_phase: assert property (p_typeb_phase) else $error("type B phase off parity"); // R5

  // R2: the driven common is the one of the current slot
  property p_slot_drive;
    (com_drive != 4'h0) |-> (com_drive == (4'h1 << s.slot));
  endproperty
  a_slot_drive: assert property (p_slot_drive) else $error("wrong common driven"); // R2

endmodule
`default_nettype wire

// ===== test/lcdfi_panel.sv
// panel model: per-pixel dc tally of common minus segment drive
`default_nettype none
module lcdfi_panel (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clr,
  input  wire logic [3:0]  com_out,
  input  wire logic [3:0]  com_drive,
  input  wire logic [17:0] seg_out,
  output var  logic        dc_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [25:0] prev;
  int          acc [4][18];

  // each dwell is tallied once when the drive changes; a real prescaler spaces ticks evenly
  always @(posedge clk or negedge resetn) begin
    if (!resetn || clr) begin
      prev <= {com_drive, com_out, seg_out};
      foreach (acc[c, s]) acc[c][s] <= 0;
    end else if ({com_drive, com_out, seg_out} !== prev) begin
      prev <= {com_drive, com_out, seg_out};
      // undriven commons sit at mid bias and are left out of the tally
      foreach (acc[c, s]) if (prev[22+c]) acc[c][s] <= acc[c][s] + int'(prev[18+c]) - int'(prev[s]);
    end
  end

  // balanced when every tallied pixel nets to zero
  always_comb begin
    dc_ok = 1'b1;
    foreach (acc[c, s]) if (acc[c][s] != 0) dc_ok = 1'b0;
  end
endmodule
`default_nettype wire

// ===== test/lcdfi_core_tb.sv
// testbench: register, scan waveform, interrupt and sleep checks of the lcd frame block
`default_nettype none
module lcdfi_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, ce, psel, penable, pwrite, lcd_tick, sleep_req;
  logic        pready, pslverr, irq, wake, dc_ok, clr, t1, wake_seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  com_out, com_drive;
  logic [17:0] seg_out;
  logic [7:0]  pix [12];
  logic [25:0] note_q [$];
  logic        typ_b, odd, half, st_f, run_f, e;
  int          mcnt, slot, cyc, fail_count, cmp_count;
  int          seed = 50929;

  lcdfi_core u_dut (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lcd_tick(lcd_tick), .sleep_req(sleep_req), .com_out(com_out),
    .com_drive(com_drive), .seg_out(seg_out), .irq(irq), .wake(wake));
  lcdfi_panel u_panel (.clk(clk), .resetn(resetn), .clr(clr), .com_out(com_out),
    .com_drive(com_drive), .seg_out(seg_out), .dc_ok(dc_ok));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, rd, e);
    check(rd, x);
  endtask

  // expected drive of the active common: phase inverts the whole row
  function automatic logic [25:0] exp_out();
    logic        ph;
    logic [17:0] row;
    ph = typ_b ? odd : half;
    row = {pix[3*slot+2][1:0], pix[3*slot+1], pix[3*slot]};
    return {4'(1 << slot), 4'({3'b000, ph} << slot), row ^ {18{ph}}};
  endfunction

  // one scan step; the reference scan advances only while the block runs
  task automatic tick();
    logic exp_w;
    exp_w = 1'b0;
    @(posedge clk);
    lcd_tick <= 1'b1;
    wake_seen <= 1'b0;
    if (run_f) begin
      if (typ_b) begin
        slot++;
        if (slot == mcnt) begin
          slot = 0;
          odd = ~odd;
        end
      end else begin
        half = ~half;
        if (!half) slot = (slot + 1) % mcnt;
      end
      if (typ_b && mcnt > 1 && slot == mcnt - 1 && odd) st_f = 1'b1;
      exp_w = typ_b && mcnt > 1 && slot == 0 && !odd && sleep_req;
      note_q.push_back(exp_out());
    end
    @(posedge clk);
    lcd_tick <= 1'b0;
    repeat (3) @(posedge clk);
    check(irq, st_f);
    check(wake_seen, exp_w);
  endtask

  // two balance periods in one waveform type and multiplex setting
  task automatic run(input logic b, input logic [1:0] mx);
    wr(8'h30, 32'h0000_0000);
    wr(8'h30, {24'h00_0000, 3'b100, b, 2'b00, mx});
    typ_b = b;
    mcnt = mx + 1;
    slot = 0;
    half = 1'b0;
    odd = 1'b0;
    run_f = 1'b1;
    repeat (2) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    for (int i = 1; i <= 4 * mcnt; i++) begin
      tick();
      if (i % (2 * mcnt) == 0) check(dc_ok, 1'b1);
      if (b && mx == 2'h3 && i == 1) begin
        wr(8'h00, {24'h00_0000, ~pix[0]});
        rdchk(8'h00, {24'h00_0000, pix[0]});
        rdchk(8'h30, 32'h0000_00B3);
        rdchk(8'h34, 32'h0000_0002);
      end
      if (st_f) begin
        rdchk(8'h34, 32'h0000_0001);
        st_f = 1'b0;
        // update only inside the open window
        if (mx == 2'h3) begin
          pix[0] = 8'($random(seed));
          wr(8'h00, {24'h00_0000, pix[0]});
          rdchk(8'h00, {24'h00_0000, pix[0]});
        end
      end
    end
    rdchk(8'h34, 32'h0000_0000);
  endtask

  // a stopped scan ignores ticks and holds slot zero
  task automatic stopchk(input logic [7:0] c);
    wr(8'h30, 32'h0000_0000);
    wr(8'h30, {24'h00_0000, c});
    run_f = 1'b0;
    tick();
    apb(1'b0, 8'h3C, 32'h0000_0000, rd, e);
  endtask

  // monitor: each scan step lands the edge after its tick
  always @(posedge clk) begin
    t1 <= lcd_tick;
    if (wake) wake_seen <= 1'b1;
    if (t1 && note_q.size() > 0) check({com_drive, com_out, seg_out}, note_q.pop_front());
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    {resetn, psel, penable, pwrite, lcd_tick, sleep_req, clr, t1, wake_seen} = '0;
    {paddr, pwdata, cyc, fail_count, cmp_count} = '0;
    {run_f, st_f} = 2'b00;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    // reset values: only the control word is nonzero
    for (int a = 0; a < 16; a++) rdchk(8'(4 * a), (a == 12) ? 32'h0000_0003 : 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000, rd, e);
    check(rd, 32'h0000_0000);
    check(e, 1'b1);
    apb(1'b1, 8'h06, 32'h0000_00FF, rd, e);
    check(e, 1'b1);
    for (int i = 0; i < 12; i++) begin
      pix[i] = 8'($random(seed));
      wr(8'(4 * i), {24'h00_0000, pix[i]});
      rdchk(8'(4 * i), {24'h00_0000, pix[i]});
    end
    wr(8'h38, 32'h0000_0001);
    // sleep with the stop select clear keeps scanning
    sleep_req <= 1'b1;
    for (int m = 0; m < 8; m++) run(m[2], m[1:0]);
    // sleep that stops the panel is only asked for after a balanced pair
    stopchk(8'hD3);
    check(rd & 32'h0000_001E, 32'h0000_0000);
    stopchk(8'h9B);
    check(rd & 32'h0000_001E, 32'h0000_0000);
    sleep_req <= 1'b0;
    // clock enable low must hold the scan where it stands
    ce <= 1'b0;
    run_f = 1'b0;
    tick();
    ce <= 1'b1;
    run_f = 1'b1;
    tick();
    rdchk(8'h3C, 32'h0000_0003);
    report_and_stop();
  end
endmodule
`default_nettype wire
